//--- inc/tmr_consts.vh
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// register byte addresses
`define TMR_ADDR_CONTROL 8'h00
`define TMR_ADDR_COUNT 8'h04
`define TMR_ADDR_COMPARE 8'h08
`define TMR_ADDR_MASK 8'h0C
`define TMR_ADDR_FLAGS 8'h10

// control fields
`define TMR_CTL_FORCE 7
`define TMR_CTL_WGM0 6
`define TMR_CTL_COM_HI 5
`define TMR_CTL_COM_LO 4
`define TMR_CTL_WGM1 3
`define TMR_CTL_CS_HI 2
`define TMR_CTL_CS_LO 0

// mask and flag bit positions
`define TMR_BIT_OVF 1
`define TMR_BIT_CMP 0

// waveform modes {wgm1,wgm0}
`define TMR_WGM_NORMAL 2'h0
`define TMR_WGM_PHASE 2'h1
`define TMR_WGM_CTC 2'h2
`define TMR_WGM_FAST 2'h3

// compare output modes
`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3

// clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7

// prescaler tap masks (low bits all ones marks the tap)
`define TMR_PRE_W 10
`define TMR_PRE_M8 10'h007
`define TMR_PRE_M64 10'h03F
`define TMR_PRE_M256 10'h0FF
`define TMR_PRE_M1024 10'h3FF

// counter limits and reset values
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`define TMR_RST8 8'h00

// axi responses
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

//--- verilog/tmr_timer8.v
`include "tmr_consts.vh"

module tmr_timer8
(
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// axi4-lite write address
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [7:0] i_s_axi_awaddr,
	// axi4-lite write data
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	// axi4-lite write response
	output wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	output wire [1:0] o_s_axi_bresp,
	// axi4-lite read address
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	input wire [7:0] i_s_axi_araddr,
	// axi4-lite read data
	output wire o_s_axi_rvalid,
	input wire i_s_axi_rready,
	output wire [31:0] o_s_axi_rdata,
	output wire [1:0] o_s_axi_rresp,
	// interrupt handshake with the cpu
	input wire i_global_irq_en,
	input wire i_ovf_vec_ack,
	input wire i_cmp_vec_ack,
	output wire o_ovf_irq,
	output wire o_cmp_irq,
	// compare output pin and its port
	input wire i_port_dir_out,
	input wire i_port_data,
	output wire o_compare_output_pin,
	output wire o_compare_output_pin_oe_n,
	// external count pin
	input wire i_external_count_pin
);

	// software registers
	reg [6:0] ctl_reg;
	reg [7:0] count_reg;
	reg [7:0] compare_reg;
	reg [7:0] cmp_act_reg;
	reg [1:0] mask_reg;
	reg [1:0] flags_reg;
	reg oc_reg;
	reg down_reg;
	reg block_reg;
	reg [`TMR_PRE_W-1:0] pre_reg;
	reg ext_s1_reg;
	reg ext_s2_reg;
	reg ext_prev_reg;

	// axi state
	reg aw_full_reg;
	reg [7:0] aw_addr_reg;
	reg w_full_reg;
	reg [31:0] w_data_reg;
	reg w_strb0_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;

	wire [1:0] wgm;
	wire [1:0] com;
	wire [2:0] cs;
	wire is_pwm;
	wire do_write;
	wire wr_ctl;
	wire wr_cnt;
	wire wr_cmp;
	wire wr_msk;
	wire wr_flg;
	wire wr_hit;
	reg tick;
	wire at_top;
	wire match;
	wire ext_rise;
	wire ext_fall;
	wire top_cmp;
	reg [7:0] count_next;
	reg down_next;
	reg oc_next;
	reg ovf_set;
	reg [7:0] rd_val;
	reg rd_hit;

	assign wgm = {ctl_reg[`TMR_CTL_WGM1], ctl_reg[`TMR_CTL_WGM0]};
	assign com = ctl_reg[`TMR_CTL_COM_HI:`TMR_CTL_COM_LO];
	assign cs = ctl_reg[`TMR_CTL_CS_HI:`TMR_CTL_CS_LO];
	assign is_pwm = ctl_reg[`TMR_CTL_WGM0];

	// axi4-lite write path
	assign o_s_axi_awready = ~aw_full_reg;
	assign o_s_axi_wready = ~w_full_reg;
	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp = bresp_reg;
	assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign wr_ctl = do_write & w_strb0_reg & (aw_addr_reg == `TMR_ADDR_CONTROL);
	assign wr_cnt = do_write & w_strb0_reg & (aw_addr_reg == `TMR_ADDR_COUNT);
	assign wr_cmp = do_write & w_strb0_reg & (aw_addr_reg == `TMR_ADDR_COMPARE);
	assign wr_msk = do_write & w_strb0_reg & (aw_addr_reg == `TMR_ADDR_MASK);
	assign wr_flg = do_write & w_strb0_reg & (aw_addr_reg == `TMR_ADDR_FLAGS);
	assign wr_hit = (aw_addr_reg == `TMR_ADDR_CONTROL) | (aw_addr_reg == `TMR_ADDR_COUNT)
		| (aw_addr_reg == `TMR_ADDR_COMPARE) | (aw_addr_reg == `TMR_ADDR_MASK)
		| (aw_addr_reg == `TMR_ADDR_FLAGS);

	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `TMR_RESP_OKAY;
		end
		else
		begin
			if (i_s_axi_awvalid && !aw_full_reg)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= {i_s_axi_awaddr[7:2], 2'b00};
			end
			if (i_s_axi_wvalid && !w_full_reg)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= i_s_axi_wdata;
				w_strb0_reg <= i_s_axi_wstrb[0];
			end
			if (do_write)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
			end
			if (bvalid_reg && i_s_axi_bready)
			begin
				bvalid_reg <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
			end
		end
	end

	// axi4-lite read path
	assign o_s_axi_arready = ~rvalid_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata = rdata_reg;
	assign o_s_axi_rresp = rresp_reg;

	always @*
	begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		case ({i_s_axi_araddr[7:2], 2'b00})
			// force strobe always reads zero
			`TMR_ADDR_CONTROL: rd_val = {1'b0, ctl_reg};
			`TMR_ADDR_COUNT: rd_val = count_reg;
			`TMR_ADDR_COMPARE: rd_val = compare_reg;
			`TMR_ADDR_MASK: rd_val = {6'h00, mask_reg};
			`TMR_ADDR_FLAGS: rd_val = {6'h00, flags_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `TMR_RESP_OKAY;
		end
		else if (i_s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= {24'h000000, rd_val};
			rresp_reg <= rd_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
		end
		else if (rvalid_reg && i_s_axi_rready)
		begin
			rvalid_reg <= 1'b0;
		end
	end

	// clock source
	// two-flop synchroniser then edge detector; the pin counts whatever
	// drives it, port direction is never looked at
	assign ext_rise = ext_s2_reg & ~ext_prev_reg;
	assign ext_fall = ~ext_s2_reg & ext_prev_reg;

	always @*
	begin
		case (cs)
			`TMR_CS_STOP: tick = 1'b0;
			`TMR_CS_DIV1: tick = 1'b1;
			`TMR_CS_DIV8: tick = (pre_reg & `TMR_PRE_M8) == `TMR_PRE_M8;
			`TMR_CS_DIV64: tick = (pre_reg & `TMR_PRE_M64) == `TMR_PRE_M64;
			`TMR_CS_DIV256: tick = (pre_reg & `TMR_PRE_M256) == `TMR_PRE_M256;
			`TMR_CS_DIV1024: tick = pre_reg == `TMR_PRE_M1024;
			`TMR_CS_EXT_FALL: tick = ext_fall;
			`TMR_CS_EXT_RISE: tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end

	// counter
	assign at_top = (wgm == `TMR_WGM_CTC) ? (count_reg == cmp_act_reg)
		: (count_reg == `TMR_MAX);
	// continuous equality, blocked on the tick after a software write to the count
	assign match = tick & (count_reg == cmp_act_reg) & ~block_reg;
	// pwm special case: compare at top with upper mode bit ignores the match
	assign top_cmp = is_pwm & com[1] & (cmp_act_reg == `TMR_MAX);

	always @*
	begin
		count_next = count_reg;
		down_next = down_reg;
		ovf_set = 1'b0;
		if (tick)
		begin
			case (wgm)
				`TMR_WGM_PHASE:
				begin
					if (!down_reg && count_reg == `TMR_MAX)
					begin
						down_next = 1'b1;
						count_next = count_reg - 8'h01;
					end
					else if (down_reg && count_reg == `TMR_BOTTOM)
					begin
						down_next = 1'b0;
						ovf_set = 1'b1;
						count_next = count_reg + 8'h01;
					end
					else
						count_next = down_reg ? count_reg - 8'h01 : count_reg + 8'h01;
				end
				`TMR_WGM_CTC:
				begin
					down_next = 1'b0;
					ovf_set = count_reg == `TMR_MAX;
					count_next = (count_reg == cmp_act_reg) ? `TMR_BOTTOM
						: count_reg + 8'h01;
				end
				default:
				begin
					down_next = 1'b0;
					ovf_set = count_reg == `TMR_MAX;
					count_next = count_reg + 8'h01;
				end
			endcase
		end
	end

	// waveform output
	always @*
	begin
		oc_next = oc_reg;
		if (tick)
		begin
			case (wgm)
				`TMR_WGM_FAST:
				begin
					if (match && !top_cmp && com == `TMR_COM_CLEAR)
						oc_next = 1'b0;
					else if (match && !top_cmp && com == `TMR_COM_SET)
						oc_next = 1'b1;
					if (at_top && com[1])
						oc_next = ~com[0];
				end
				`TMR_WGM_PHASE:
				begin
					if (match && !top_cmp && com[1])
						oc_next = down_reg ? ~com[0] : com[0];
					if (top_cmp && at_top && !down_reg)
						oc_next = ~com[0];
				end
				default:
				begin
					if (match)
					begin
						case (com)
							`TMR_COM_TOGGLE: oc_next = ~oc_reg;
							`TMR_COM_CLEAR: oc_next = 1'b0;
							`TMR_COM_SET: oc_next = 1'b1;
							default: oc_next = oc_reg;
						endcase
					end
				end
			endcase
		end
	end

	// pin mux: compare output wins over the port while any mode bit is set
	assign o_compare_output_pin = (com != `TMR_COM_OFF) ? oc_reg : i_port_data;
	// enable is active low; driver only on when direction says output
	assign o_compare_output_pin_oe_n = ~i_port_dir_out;

	// interrupts
	assign o_ovf_irq = flags_reg[`TMR_BIT_OVF] & mask_reg[`TMR_BIT_OVF] & i_global_irq_en;
	assign o_cmp_irq = flags_reg[`TMR_BIT_CMP] & mask_reg[`TMR_BIT_CMP] & i_global_irq_en;

	// state registers
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctl_reg <= 7'h00;
			count_reg <= `TMR_RST8;
			compare_reg <= `TMR_RST8;
			cmp_act_reg <= `TMR_RST8;
			mask_reg <= 2'h0;
			flags_reg <= 2'h0;
			oc_reg <= 1'b0;
			down_reg <= 1'b0;
			block_reg <= 1'b0;
			pre_reg <= {`TMR_PRE_W{1'b0}};
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end
		else
		begin
			pre_reg <= pre_reg + 1'b1;
			ext_s1_reg <= i_external_count_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_prev_reg <= ext_s2_reg;
			oc_reg <= oc_next;
			down_reg <= down_next;
			if (wr_ctl)
				ctl_reg <= w_data_reg[6:0];
			if (wr_cmp)
				compare_reg <= w_data_reg[7:0];
			if (wr_msk)
				mask_reg <= {w_data_reg[`TMR_BIT_OVF], w_data_reg[`TMR_BIT_CMP]};
			// active compare: immediate outside PWM, at top inside it
			if (!is_pwm
				|| (wgm == `TMR_WGM_PHASE && tick && at_top && !down_reg)
				|| (wgm == `TMR_WGM_FAST && tick && at_top))
				cmp_act_reg <= compare_reg;
			// software write to the count wins over a tick in the same cycle
			if (wr_cnt)
			begin
				count_reg <= w_data_reg[7:0];
				block_reg <= 1'b1;
			end
			else
			begin
				count_reg <= count_next;
				if (tick)
					block_reg <= 1'b0;
			end
			// flags: hardware set wins over any clear in the same cycle
			if (ovf_set)
				flags_reg[`TMR_BIT_OVF] <= 1'b1;
			else if (i_ovf_vec_ack || (wr_flg && w_data_reg[`TMR_BIT_OVF]))
				flags_reg[`TMR_BIT_OVF] <= 1'b0;
			if (match)
				flags_reg[`TMR_BIT_CMP] <= 1'b1;
			else if (i_cmp_vec_ack || (wr_flg && w_data_reg[`TMR_BIT_CMP]))
				flags_reg[`TMR_BIT_CMP] <= 1'b0;
		end
	end

endmodule

//--- test/tmr_timer8_monitor.sv
module tmr_timer8_monitor
(
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// register bus
	input wire i_s_axi_awvalid,
	input wire o_s_axi_awready,
	input wire i_s_axi_wvalid,
	input wire o_s_axi_wready,
	input wire o_s_axi_bvalid,
	input wire i_s_axi_arvalid,
	input wire o_s_axi_arready,
	input wire o_s_axi_rvalid,
	input wire i_s_axi_rready,
	input wire [31:0] o_s_axi_rdata,
	// interrupts and pin
	input wire i_global_irq_en,
	input wire i_ovf_vec_ack,
	input wire i_cmp_vec_ack,
	input wire o_ovf_irq,
	input wire o_cmp_irq,
	input wire i_port_dir_out,
	input wire o_compare_output_pin_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// no register write lands at this edge
	wire no_wr = o_s_axi_awready && o_s_axi_wready;
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	a_oe_dir_follow: assert property (o_compare_output_pin_oe_n == !i_port_dir_out)
		else $error("pin enable does not follow direction");
	a_ovf_irq_gate: assert property (!i_global_irq_en |-> !o_ovf_irq)
		else $error("overflow irq without global enable");
	a_cmp_irq_gate: assert property (!i_global_irq_en |-> !o_cmp_irq)
		else $error("compare irq without global enable");
	a_ovf_irq_hold: assert property (o_ovf_irq && !i_ovf_vec_ack && no_wr
		|=> o_ovf_irq || !i_global_irq_en) else $error("overflow irq dropped");
	a_cmp_irq_hold: assert property (o_cmp_irq && !i_cmp_vec_ack && no_wr
		|=> o_cmp_irq || !i_global_irq_en) else $error("compare irq dropped");
	a_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read not answered");
	a_rd_data_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data moved");
	a_wr_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
		&& o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("write not answered");
endmodule
bind tmr_timer8 tmr_timer8_monitor u_tmr_timer8_monitor (.i_clk_sys, .i_rst_n,
	.i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid,
	.i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata,
	.i_global_irq_en, .i_ovf_vec_ack, .i_cmp_vec_ack, .o_ovf_irq, .o_cmp_irq,
	.i_port_dir_out, .o_compare_output_pin_oe_n);

//--- test/tmr_timer8_test.sv
`include "tmr_consts.vh"
module tmr_timer8_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic gie = 0, oack = 0, cack = 0, dir = 0, pdat = 0, ext = 0;
	wire awr, wrdy, bv, arr, rv, oirq, cirq, pin, oen;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer err_total = 0, checks = 0;
	tmr_timer8 u_tmr_timer8 (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
		.i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
		.o_s_axi_bvalid(bv), .i_s_axi_bready(brdy), .o_s_axi_bresp(bresp),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rrdy), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.i_global_irq_en(gie), .i_ovf_vec_ack(oack), .i_cmp_vec_ack(cack),
		.o_ovf_irq(oirq), .o_cmp_irq(cirq), .i_port_dir_out(dir), .i_port_data(pdat),
		.o_compare_output_pin(pin), .o_compare_output_pin_oe_n(oen), .i_external_count_pin(ext));
	always #10 clk = ~clk;
	task print_verdict;
		$display("checks=%0d mismatches=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chkr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
		checks++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			err_total++;
			$display("MISMATCH t=%0t got %0d range %0d..%0d", $time, g, lo, hi);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 0;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		brdy <= 1'b1;
		while (!done)
		begin
			@(posedge clk);
			if (awr === 1'b1)
				awv <= 1'b0;
			if (wrdy === 1'b1)
				wv <= 1'b0;
			done = (bv === 1'b1);
		end
		brdy <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 0;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rrdy <= 1'b1;
		while (!done)
		begin
			@(posedge clk);
			if (arr === 1'b1)
				arv <= 1'b0;
			done = (rv === 1'b1);
		end
		d = rdata;
		rrdy <= 1'b0;
		chk(32'(rresp), 32'(er));
	endtask
	task w(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, `TMR_RESP_OKAY);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d, `TMR_RESP_OKAY);
		chk(d, e);
	endtask
	function logic [31:0] ctl(input logic [1:0] wg, input logic [1:0] cm, input logic [2:0] cs);
		return {24'h0, 1'b0, wg[0], cm, wg[1], cs};
	endfunction
	task t_regs;
		logic [31:0] d;
		rchk(`TMR_ADDR_CONTROL, 32'h0);
		rchk(`TMR_ADDR_COUNT, 32'h0);
		rchk(`TMR_ADDR_COMPARE, 32'h0);
		rchk(`TMR_ADDR_MASK, 32'h0);
		rchk(`TMR_ADDR_FLAGS, 32'h0);
		w(`TMR_ADDR_COMPARE, 32'hA5);
		rchk(`TMR_ADDR_COMPARE, 32'hA5);
		w(`TMR_ADDR_COUNT, 32'h3C);
		rchk(`TMR_ADDR_COUNT, 32'h3C);
		wr(8'h14, 32'hFF, `TMR_RESP_SLVERR);
		rd(8'h14, d, `TMR_RESP_SLVERR);
		chk(d, 32'h0);
		chk(32'(oen), 32'h0);
		dir <= 1'b0;
		@(posedge clk);
		chk(32'(oen), 32'h1);
		dir <= 1'b1;
		$display("test regs done");
	endtask
	task t_clk;
		integer n;
		logic [31:0] d;
		logic [3:0] cs;
		for (cs = 1; cs <= 5; cs++)
		begin
			n = (cs == 1) ? 1 : (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
			w(`TMR_ADDR_COUNT, 32'h0);
			w(`TMR_ADDR_CONTROL, ctl(`TMR_WGM_NORMAL, `TMR_COM_OFF, cs[2:0]));
			repeat (16 * n) @(posedge clk);
			w(`TMR_ADDR_CONTROL, 32'h0);
			rd(`TMR_ADDR_COUNT, d, `TMR_RESP_OKAY);
			chkr(d, 16, (n == 1) ? 24 : 17);
		end
		repeat (50) @(posedge clk);
		rchk(`TMR_ADDR_COUNT, d);
		$display("test clock select done");
	endtask
	task pulses(input integer k);
		repeat (k)
		begin
			ext <= 1'b1;
			repeat (4) @(posedge clk);
			ext <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task t_ext;
		w(`TMR_ADDR_COUNT, 32'h0);
		w(`TMR_ADDR_CONTROL, ctl(`TMR_WGM_NORMAL, `TMR_COM_OFF, `TMR_CS_EXT_RISE));
		pulses(5);
		rchk(`TMR_ADDR_COUNT, 32'h5);
		w(`TMR_ADDR_CONTROL, ctl(`TMR_WGM_NORMAL, `TMR_COM_OFF, `TMR_CS_EXT_FALL));
		pulses(3);
		rchk(`TMR_ADDR_COUNT, 32'h8);
		$display("test external count done");
	endtask
	task t_flags;
		w(`TMR_ADDR_CONTROL, 32'h0);
		w(`TMR_ADDR_FLAGS, 32'h3);
		w(`TMR_ADDR_COMPARE, 32'h5);
		w(`TMR_ADDR_COUNT, 32'h0);
		w(`TMR_ADDR_MASK, 32'h3);
		gie <= 1'b1;
		w(`TMR_ADDR_CONTROL, ctl(`TMR_WGM_NORMAL, `TMR_COM_OFF, `TMR_CS_DIV1));
		repeat (300) @(posedge clk);
		w(`TMR_ADDR_CONTROL, 32'h0);
		chk(32'(oirq), 32'h1);
		chk(32'(cirq), 32'h1);
		rchk(`TMR_ADDR_FLAGS, 32'h3);
		gie <= 1'b0;
		@(posedge clk);
		chk(32'(oirq), 32'h0);
		gie <= 1'b1;
		w(`TMR_ADDR_FLAGS, 32'h0);
		rchk(`TMR_ADDR_FLAGS, 32'h3);
		w(`TMR_ADDR_FLAGS, 32'h1);
		rchk(`TMR_ADDR_FLAGS, 32'h2);
		chk(32'(cirq), 32'h0);
		oack <= 1'b1;
		@(posedge clk);
		oack <= 1'b0;
		@(posedge clk);
		chk(32'(oirq), 32'h0);
		rchk(`TMR_ADDR_FLAGS, 32'h0);
		gie <= 1'b0;
		$display("test flags done");
	endtask
	task t_sup;
		w(`TMR_ADDR_COMPARE, 32'h20);
		w(`TMR_ADDR_COUNT, 32'h20);
		w(`TMR_ADDR_CONTROL, ctl(`TMR_WGM_NORMAL, `TMR_COM_OFF, `TMR_CS_DIV1));
		repeat (20) @(posedge clk);
		w(`TMR_ADDR_CONTROL, 32'h0);
		rchk(`TMR_ADDR_FLAGS, 32'h0);
		$display("test match block done");
	endtask
	task wave(input logic [1:0] wg, input logic [1:0] cm, input logic [7:0] cv,
		input logic pd, input integer nc, input integer lo, input integer hi);
		integer h;
		h = 0;
		pdat <= pd;
		w(`TMR_ADDR_CONTROL, 32'h0);
		w(`TMR_ADDR_COMPARE, {24'h0, cv});
		w(`TMR_ADDR_COUNT, 32'h0);
		w(`TMR_ADDR_CONTROL, ctl(wg, cm, `TMR_CS_DIV1));
		repeat (520) @(posedge clk);
		repeat (nc)
		begin
			@(posedge clk);
			if (pin === 1'b1)
				h++;
		end
		chkr(h, lo, hi);
	endtask
	task t_wave;
		wave(`TMR_WGM_NORMAL, `TMR_COM_OFF, 8'h40, 1'b1, 256, 256, 256);
		wave(`TMR_WGM_NORMAL, `TMR_COM_SET, 8'h40, 1'b0, 256, 256, 256);
		wave(`TMR_WGM_NORMAL, `TMR_COM_CLEAR, 8'h40, 1'b1, 256, 0, 0);
		wave(`TMR_WGM_CTC, `TMR_COM_TOGGLE, 8'h0F, 1'b0, 256, 120, 136);
		wave(`TMR_WGM_FAST, `TMR_COM_CLEAR, 8'h40, 1'b0, 256, 60, 70);
		wave(`TMR_WGM_FAST, `TMR_COM_SET, 8'h40, 1'b0, 256, 186, 196);
		wave(`TMR_WGM_FAST, `TMR_COM_CLEAR, 8'hFF, 1'b0, 256, 256, 256);
		wave(`TMR_WGM_PHASE, `TMR_COM_CLEAR, 8'h40, 1'b0, 510, 122, 134);
		wave(`TMR_WGM_PHASE, `TMR_COM_SET, 8'h40, 1'b0, 510, 376, 388);
		$display("test waveforms done");
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		dir <= 1'b1;
		t_regs;
		t_clk;
		t_ext;
		t_flags;
		t_sup;
		t_wave;
		print_verdict;
	end
	initial
	begin
		#1500000;
		err_total++;
		print_verdict;
	end
endmodule
